// ==== tb/sarc_classifier_assertions.sv ====
// Port checker for the accessory classifier
`default_nettype none
module sarc_chk (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic [7:0] reg_addr,
	input wire logic reg_rd_en,
	input wire logic [7:0] reg_rdata,
	input wire logic meas_done,
	input wire logic meas_pin,
	input wire logic [3:0] pin_one_acc_valid,
	input wire logic [3:0] pin_two_acc_valid,
	input wire logic result_strobe
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);
	AST_STROBE: assert property (meas_done |=> result_strobe) else $error("no strobe");
	AST_QUIET: assert property (!meas_done |=> !result_strobe) else $error("extra strobe");
	AST_SRC: assert property (result_strobe |-> $past(meas_done)) else $error("no cause");
	AST_IDLE_ONE: assert property (!meas_done |=> $stable(pin_one_acc_valid))
		else $error("pin one moved");
	AST_IDLE_TWO: assert property (!meas_done |=> $stable(pin_two_acc_valid))
		else $error("pin two moved");
	AST_SIDE_ONE: assert property (meas_done && meas_pin |=> $stable(pin_one_acc_valid))
		else $error("wrong pin updated");
	AST_SIDE_TWO: assert property (meas_done && !meas_pin |=> $stable(pin_two_acc_valid))
		else $error("pin two updated by pin one result");
	AST_RST_CLEAR: assert property (disable iff (1'b0) rst |=> reg_rdata == 8'h00 &&
		pin_one_acc_valid == 4'h0 && pin_two_acc_valid == 4'h0 && !result_strobe)
		else $error("outputs not cleared by reset");
	AST_RD_HOLD: assert property (!reg_rd_en |=> $stable(reg_rdata))
		else $error("read data moved");
	AST_UNMAPPED: assert property (reg_rd_en && (reg_addr < 8'h34 || reg_addr > 8'h3f)
		|=> reg_rdata == 8'h00) else $error("unmapped read");
endmodule : sarc_chk
bind sarc_classifier sarc_chk u_chk (
	.core_clk(core_clk),
	.rst(rst),
	.reg_addr(reg_addr),
	.reg_rd_en(reg_rd_en),
	.reg_rdata(reg_rdata),
	.meas_done(meas_done),
	.meas_pin(meas_pin),
	.pin_one_acc_valid(pin_one_acc_valid),
	.pin_two_acc_valid(pin_two_acc_valid),
	.result_strobe(result_strobe)
);
`default_nettype wire

// ==== tb/sarc_classifier_tb.sv ====
// Register and classification bench for the accessory classifier
`default_nettype none
module sarc_classifier_tb;
	timeunit 1ns / 1ps;
	logic core_clk = 1'b0, rst = 1'b1, reg_wr_en = 1'b0, reg_rd_en = 1'b0, req = 1'b0;
	logic meas_pin = 1'b0, meas_done, result_strobe;
	logic [1:0] pu;
	logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, adc, reg_rdata;
	logic [9:0] req_code = 10'h000;
	logic [3:0] pin_one_acc_valid, pin_two_acc_valid;
	int err_total = 0, comparisons = 0;
	logic [7:0] rv [12] = '{8'h74, 8'h66, 8'h01, 8'hd9, 8'hbf, 8'h01,
		8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
	always #4 core_clk = ~core_clk;
	sarc_meas_model u_model (.core_clk, .req, .req_code, .meas_done, .pu, .adc);
	sarc_classifier DUT (.core_clk, .rst, .reg_addr, .reg_wdata, .reg_wr_en, .reg_rd_en,
		.reg_rdata, .meas_done, .meas_pin, .sideband_final_pullup_code(pu),
		.sideband_final_adc_code(adc), .pin_one_acc_valid, .pin_two_acc_valid, .result_strobe);
	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		comparisons++;
		err_total += int'(got !== exp);
		if (got !== exp) $display("wrong value %s expected %h seen %h", what, exp, got);
	endtask : chk
	task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
		{reg_addr, reg_wdata, reg_wr_en, reg_rd_en} <= {a, d, w, !w};
		@(posedge core_clk);
		{reg_wr_en, reg_rd_en} <= 2'b00;
		#1;
		if (!w) chk("reg_rdata", d, reg_rdata);
		// Next access starts on an edge, one idle edge after the enables drop
		@(posedge core_clk);
	endtask : acc
	task automatic rd_reset();
		for (int i = 11; i >= 0; i--) acc(1'b0, 8'h34 + 8'(i), rv[i]);
		acc(1'b0, 8'h40, 8'h00);
	endtask : rd_reset
	// Pin and codes held after the pulse so the classifier still sees them in the done cycle
	task automatic mc(input logic p, input logic [9:0] c, input logic [3:0] e);
		{meas_pin, req_code, req} <= {p, c, 1'b1};
		@(posedge core_clk);
		req <= 1'b0;
		@(posedge core_clk);
		#1;
		chk("strobe_valid", {4'h1, e},
			{3'h0, result_strobe, p ? pin_two_acc_valid : pin_one_acc_valid});
		@(posedge core_clk);
	endtask : mc
	task automatic wrap_up();
		$display("comparisons %0d err_total %0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask : wrap_up
	initial begin
		repeat (4) @(posedge core_clk);
		rst <= 1'b0;
		rd_reset();
		mc(1'b0, 10'h166, 4'h1);
		mc(1'b1, 10'h1d9, 4'h2);
		mc(1'b0, 10'h000, 4'hc);
		mc(1'b0, 10'h0ff, 4'h0);
		acc(1'b1, 8'h3b, 8'h20);
		acc(1'b1, 8'h3c, 8'hfe);
		acc(1'b0, 8'h3c, 8'h02);
		mc(1'b0, 10'h220, 4'h4);
		acc(1'b1, 8'h3f, 8'h03);
		mc(1'b1, 10'h300, 4'h8);
		for (int i = 0; i < 12; i++) begin
			acc(1'b1, 8'h34 + 8'(i), 8'ha4 + 8'(i));
			acc(1'b0, 8'h34 + 8'(i), (8'ha4 + 8'(i)) & ((i % 3 == 2) ? 8'h03 : 8'hff));
		end
		// Inverted bounds leave accessory 5 empty even with its pullup matching
		mc(1'b1, 10'h3ad, 4'h0);
		mc(1'b0, 10'h0aa, 4'h4);
		rst <= 1'b1;
		repeat (2) @(posedge core_clk);
		chk("valid_reset", 8'h00, {pin_two_acc_valid, pin_one_acc_valid});
		chk("rdata_reset", 8'h00, reg_rdata);
		rst <= 1'b0;
		rd_reset();
		wrap_up();
	end
endmodule : sarc_classifier_tb
`default_nettype wire

// ==== tb/sarc_meas_model.sv ====
// Measurement engine stand-in: done pulse and final codes
`default_nettype none
module sarc_meas_model (
	input wire logic core_clk,
	input wire logic req,
	input wire logic [9:0] req_code,
	output logic meas_done,
	output logic [1:0] pu,
	output logic [7:0] adc
);
	timeunit 1ns / 1ps;
	always_ff @(posedge core_clk) meas_done <= req;
	// Codes invert outside the done cycle so stale values never match by luck
	assign {pu, adc} = meas_done ? req_code : ~req_code;
endmodule : sarc_meas_model
`default_nettype wire

// ==== verilog/sarc_classifier.sv ====
// Accessory resistor classifier with its threshold registers
//
// Summary of operation
// - Accessory 2 matches when the final pullup equals its pullup code and the code is in range.
// - Accessory 3 matches when the final pullup equals its pullup code and the code is in range.
// - Accessory 4 matches when the final pullup equals its pullup code and the code is in range.
// - The accessory 2 lower bound is an 8-bit code compared to the final code, reset 0x66.
// - Accessory 3 bounds reset to 0xd9 upper and 0xbf lower, its pullup code to 8 uA.
// - The accessory 5 upper bound is a read/write 8-bit code that resets to zero.
// - The accessory 5 lower bound resets to zero and its pullup code to 2 uA.
// - Accessory 5 matches when the final pullup equals its pullup code and the code is in range.
// - The engine reports pullup 00 for abort or open and 11 for ground.
// - The engine reports code 0x00 for abort or ground and 0xff for open.
`default_nettype none
module sarc_classifier (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr_en,
	input wire logic reg_rd_en,
	output logic [7:0] reg_rdata,
	input wire logic meas_done,
	input wire logic meas_pin,
	input wire logic [1:0] sideband_final_pullup_code,
	input wire logic [7:0] sideband_final_adc_code,
	output logic [3:0] pin_one_acc_valid,
	output logic [3:0] pin_two_acc_valid,
	output logic result_strobe
);
	// ==========================================================
	// Threshold registers, index 0 is accessory 2
	logic [7:0] lower_code [sarc_pkg::NUM_ACC];
	logic [7:0] upper_code [sarc_pkg::NUM_ACC];
	logic [1:0] pullup_select [sarc_pkg::NUM_ACC];
	logic [3:0] hit;
	logic [7:0] next_rdata;

	always_ff @(posedge core_clk) begin
		if (rst) begin
			lower_code[0] <= sarc_pkg::ACC2_LOWER_RST;
			upper_code[0] <= sarc_pkg::ACC2_UPPER_RST;
			pullup_select[0] <= sarc_pkg::ACC2_PULLUP_RST;
			lower_code[1] <= sarc_pkg::ACC3_LOWER_RST;
			upper_code[1] <= sarc_pkg::ACC3_UPPER_RST;
			pullup_select[1] <= sarc_pkg::ACC3_PULLUP_RST;
			lower_code[2] <= sarc_pkg::ACC4_LOWER_RST;
			upper_code[2] <= sarc_pkg::ACC4_UPPER_RST;
			pullup_select[2] <= sarc_pkg::ACC4_PULLUP_RST;
			lower_code[3] <= sarc_pkg::ACC5_LOWER_RST;
			upper_code[3] <= sarc_pkg::ACC5_UPPER_RST;
			pullup_select[3] <= sarc_pkg::ACC5_PULLUP_RST;
		end else if (reg_wr_en) begin
			unique case (reg_addr)
				sarc_pkg::ACC2_UPPER_OFS: upper_code[0] <= reg_wdata;
				sarc_pkg::ACC2_LOWER_OFS: lower_code[0] <= reg_wdata;
				sarc_pkg::ACC2_PULLUP_OFS: pullup_select[0] <= reg_wdata[1:0];
				sarc_pkg::ACC3_UPPER_OFS: upper_code[1] <= reg_wdata;
				sarc_pkg::ACC3_LOWER_OFS: lower_code[1] <= reg_wdata;
				sarc_pkg::ACC3_PULLUP_OFS: pullup_select[1] <= reg_wdata[1:0];
				sarc_pkg::ACC4_LOWER_OFS: lower_code[2] <= reg_wdata;
				sarc_pkg::ACC4_UPPER_OFS: upper_code[2] <= reg_wdata;
				sarc_pkg::ACC4_PULLUP_OFS: pullup_select[2] <= reg_wdata[1:0];
				sarc_pkg::ACC5_UPPER_OFS: upper_code[3] <= reg_wdata;
				sarc_pkg::ACC5_LOWER_OFS: lower_code[3] <= reg_wdata;
				sarc_pkg::ACC5_PULLUP_OFS: pullup_select[3] <= reg_wdata[1:0];
				// Unmapped writes are dropped silently
				default: ;
			endcase
		end
	end

	// ==========================================================
	// Read path, reserved pullup bits read zero
	always_comb begin
		next_rdata = sarc_pkg::READ_ZERO;
		unique case (reg_addr)
			sarc_pkg::ACC2_UPPER_OFS: next_rdata = upper_code[0];
			sarc_pkg::ACC2_LOWER_OFS: next_rdata = lower_code[0];
			sarc_pkg::ACC2_PULLUP_OFS: next_rdata = {6'h00, pullup_select[0]};
			sarc_pkg::ACC3_UPPER_OFS: next_rdata = upper_code[1];
			sarc_pkg::ACC3_LOWER_OFS: next_rdata = lower_code[1];
			sarc_pkg::ACC3_PULLUP_OFS: next_rdata = {6'h00, pullup_select[1]};
			sarc_pkg::ACC4_LOWER_OFS: next_rdata = lower_code[2];
			sarc_pkg::ACC4_UPPER_OFS: next_rdata = upper_code[2];
			sarc_pkg::ACC4_PULLUP_OFS: next_rdata = {6'h00, pullup_select[2]};
			sarc_pkg::ACC5_UPPER_OFS: next_rdata = upper_code[3];
			sarc_pkg::ACC5_LOWER_OFS: next_rdata = lower_code[3];
			sarc_pkg::ACC5_PULLUP_OFS: next_rdata = {6'h00, pullup_select[3]};
			default: next_rdata = sarc_pkg::READ_ZERO;
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			reg_rdata <= sarc_pkg::READ_ZERO;
		end else if (reg_rd_en) begin
			reg_rdata <= next_rdata;
		end
	end

	// ==========================================================
	// Window comparators
	// Abort/open/ground arrive as 00/ff codes with fixed pullups,
	// so they are classified like any other result
	genvar gi;
	generate
		for (gi = 0; gi < sarc_pkg::NUM_ACC; gi++) begin : g_win
			sarc_window u_win (
				.lower_code(lower_code[gi]),
				.upper_code(upper_code[gi]),
				.pullup_select(pullup_select[gi]),
				.final_adc_code(sideband_final_adc_code),
				.final_pullup_code(sideband_final_pullup_code),
				.hit(hit[gi])
			);
		end
	endgenerate

	// ==========================================================
	// Result latch, one update per finished measurement per pin
	always_ff @(posedge core_clk) begin
		if (rst) begin
			pin_one_acc_valid <= 4'h0;
			pin_two_acc_valid <= 4'h0;
		end else if (meas_done) begin
			if (meas_pin == sarc_pkg::PIN_ONE) begin
				pin_one_acc_valid <= hit;
			end else begin
				pin_two_acc_valid <= hit;
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			result_strobe <= 1'b0;
		end else begin
			result_strobe <= meas_done;
		end
	end
endmodule : sarc_classifier
`default_nettype wire

// ==== verilog/sarc_pkg.sv ====
// Constants for the sideband accessory resistor classifier
`default_nettype none
package sarc_pkg;
	// ==========================================================
	// Widths
	localparam int unsigned CODE_W = 8;
	localparam int unsigned PU_W = 2;
	localparam int unsigned ADDR_W = 8;
	localparam int unsigned NUM_ACC = 4;

	// ==========================================================
	// Register offsets
	localparam logic [7:0] ACC2_UPPER_OFS = 8'h34;
	localparam logic [7:0] ACC2_LOWER_OFS = 8'h35;
	localparam logic [7:0] ACC2_PULLUP_OFS = 8'h36;
	localparam logic [7:0] ACC3_UPPER_OFS = 8'h37;
	localparam logic [7:0] ACC3_LOWER_OFS = 8'h38;
	localparam logic [7:0] ACC3_PULLUP_OFS = 8'h39;
	localparam logic [7:0] ACC4_LOWER_OFS = 8'h3a;
	localparam logic [7:0] ACC4_UPPER_OFS = 8'h3b;
	localparam logic [7:0] ACC4_PULLUP_OFS = 8'h3c;
	localparam logic [7:0] ACC5_UPPER_OFS = 8'h3d;
	localparam logic [7:0] ACC5_LOWER_OFS = 8'h3e;
	localparam logic [7:0] ACC5_PULLUP_OFS = 8'h3f;

	// ==========================================================
	// Reset values
	localparam logic [7:0] ACC2_UPPER_RST = 8'h74;
	localparam logic [7:0] ACC2_LOWER_RST = 8'h66;
	localparam logic [1:0] ACC2_PULLUP_RST = 2'h1;
	localparam logic [7:0] ACC3_UPPER_RST = 8'hd9;
	localparam logic [7:0] ACC3_LOWER_RST = 8'hbf;
	localparam logic [1:0] ACC3_PULLUP_RST = 2'h1;
	localparam logic [7:0] ACC4_UPPER_RST = 8'h00;
	localparam logic [7:0] ACC4_LOWER_RST = 8'h00;
	localparam logic [1:0] ACC4_PULLUP_RST = 2'h0;
	localparam logic [7:0] ACC5_UPPER_RST = 8'h00;
	localparam logic [7:0] ACC5_LOWER_RST = 8'h00;
	localparam logic [1:0] ACC5_PULLUP_RST = 2'h0;

	// ==========================================================
	// Pullup current codes
	localparam logic [1:0] PU_2UA = 2'h0;
	localparam logic [1:0] PU_8UA = 2'h1;
	localparam logic [1:0] PU_32UA = 2'h2;
	localparam logic [1:0] PU_128UA = 2'h3;

	// Sideband pin selector values
	localparam logic PIN_ONE = 1'b0;
	localparam logic PIN_TWO = 1'b1;

	// Read data for unmapped offsets and reserved bits
	localparam logic [7:0] READ_ZERO = 8'h00;
endpackage : sarc_pkg
`default_nettype wire

// ==== verilog/sarc_window.sv ====
// One accessory window: pullup code match plus inclusive code range
`default_nettype none
module sarc_window (
	input wire logic [7:0] lower_code,
	input wire logic [7:0] upper_code,
	input wire logic [1:0] pullup_select,
	input wire logic [7:0] final_adc_code,
	input wire logic [1:0] final_pullup_code,
	output logic hit
);
	// Inverted bounds give an empty window, never a wrap-around
	assign hit = (final_pullup_code == pullup_select) &&
		(final_adc_code >= lower_code) && (final_adc_code <= upper_code);
endmodule : sarc_window
`default_nettype wire
